//--- osb_chain.sv
module osb_chain (
  // Clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  // Conversion results
  input  wire logic [15:0]                    raw_value,
  input  wire logic                           raw_valid,
  output logic                                raw_ready,
  input  wire logic                           sample_tick,
  input  wire logic                           comp_bit,
  // Scaling
  input  wire logic [15:0]                    factory_gain,
  input  wire logic [15:0]                    factory_offset,
  input  wire logic [15:0]                    user_gain,
  input  wire logic [15:0]                    user_offset,
  // Filter
  input  wire osb_pkg::osb_filt_type          filter_mode,
  input  wire logic [osb_pkg::LP_SH_W-1:0]    lp_shift,
  input  wire logic [15:0]                    numerator_coef_0,
  input  wire logic [15:0]                    numerator_coef_1,
  input  wire logic [15:0]                    numerator_coef_2,
  input  wire logic [15:0]                    denominator_coef_1,
  input  wire logic [15:0]                    denominator_coef_2,
  // Timing modes
  input  wire logic                           high_priority,
  input  wire logic [osb_pkg::PRESC_W-1:0]    prescale,
  input  wire logic                           referenced_values,
  input  wire logic [osb_pkg::CNT_W-1:0]      ref_lines,
  input  wire logic                           clear_status,
  // Cyclic transfer
  input  wire logic                           xfer_tick,
  input  wire logic [13:0][3:0]               map_line,
  output logic                                xfer_valid_q,
  output logic [7:0]                          xfer_status_q,
  output logic [osb_pkg::CNT_W-1:0]           new_line_counter_q,
  output logic [7:0]                          comparator_bits_upper_byte_q,
  output logic [7:0]                          comparator_bits_lower_byte_q,
  output logic [13:0][15:0]                   physical_line_point_q
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic signed [15:0] sat16(
    input logic signed [47:0] v
  );
    if (v > 48'(osb_pkg::SAT_MAX)) begin
      return osb_pkg::SAT_MAX;
    end else if (v < 48'(osb_pkg::SAT_MIN)) begin
      return osb_pkg::SAT_MIN;
    end else begin
      return v[15:0];
    end
  endfunction : sat16

  function automatic logic signed [47:0] mulq(
    input logic signed [15:0] a,
    input logic signed [15:0] b,
    input int unsigned        frac
  );
    logic signed [47:0] p;
    p = 48'(a) * 48'(b);
    return p >>> frac;
  endfunction : mulq

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SCALE,
    ST_FILT,
    ST_STORE
  } osb_state_type;

  // ************************************************************
  // Input FIFO
  // ************************************************************
  logic [15:0] fifo_data;
  logic        fifo_valid;
  logic        fifo_ready;
  logic        fifo_in_ready;

  osb_fifo #(
    .WIDTH (osb_pkg::DATA_W),
    .DEPTH (osb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   (raw_value),
    .in_valid  (raw_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready)
  );

  assign raw_ready = fifo_in_ready;

  // ************************************************************
  // State
  // ************************************************************
  osb_state_type                       state_q;
  logic signed [15:0]                  raw_q;
  logic signed [15:0]                  scaled_q;
  logic signed [15:0]                  filt_q;
  logic signed [15:0]                  x1_q, x2_q, y1_q, y2_q, lp_q;
  logic [15:0][15:0]                   phys_buf_q;
  logic [15:0]                         comp_buf_q;
  logic [osb_pkg::CNT_W-1:0]           cnt_q;
  logic [osb_pkg::CNT_W-1:0]           deliv_q;
  logic [osb_pkg::PRESC_W-1:0]         presc_q;
  logic                                viol_q;
  logic                                ovf_q;

  assign fifo_ready = (state_q == ST_IDLE);

  // ************************************************************
  // Scaling
  // ************************************************************
  wire logic signed [47:0] gain_c   = mulq(factory_gain, user_gain,
                                           osb_pkg::GAIN_FRAC);
  wire logic signed [47:0] offset_c = mulq(factory_gain, factory_offset,
                                           osb_pkg::GAIN_FRAC)
                                      + 48'($signed(user_offset));
  wire logic signed [63:0] kx       = 64'(gain_c) * 64'(raw_q);
  wire logic signed [47:0] scale_wide = 48'(kx >>> osb_pkg::GAIN_FRAC)
                                        + offset_c;

  // ************************************************************
  // Filters
  // ************************************************************
  wire logic signed [47:0] lp1_w = 48'(lp_q)
    + ((48'(scaled_q) - 48'(lp_q)) >>> lp_shift);
  wire logic signed [15:0] lp1_s = sat16(lp1_w);
  wire logic signed [47:0] lp2_w = 48'(y1_q)
    + ((48'(lp1_s) - 48'(y1_q)) >>> lp_shift);
  wire logic signed [47:0] iir_w =
      mulq(numerator_coef_0, scaled_q, osb_pkg::COEF_FRAC)
    + mulq(numerator_coef_1, x1_q, osb_pkg::COEF_FRAC)
    + mulq(numerator_coef_2, x2_q, osb_pkg::COEF_FRAC)
    - mulq(denominator_coef_1, y1_q, osb_pkg::COEF_FRAC)
    - mulq(denominator_coef_2, y2_q, osb_pkg::COEF_FRAC);

  logic signed [15:0] filt_c;
  always_comb begin
    case (filter_mode)
      osb_pkg::FILT_LP1: filt_c = lp1_s;
      osb_pkg::FILT_LP2: filt_c = sat16(lp2_w);
      osb_pkg::FILT_IIR: filt_c = sat16(iir_w);
      default:           filt_c = scaled_q;
    endcase
  end

  // ************************************************************
  // Sequencing and timing modes
  // ************************************************************
  wire store_w     = (state_q == ST_STORE);
  wire presc_wrap  = (presc_q >= prescale);
  wire logic_tick  = high_priority ? store_w
                                   : (sample_tick && presc_wrap);
  wire overrun     = high_priority && sample_tick
                     && (state_q != ST_IDLE);
  wire lost_sample = raw_valid && !fifo_in_ready;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:  state_q <= fifo_valid ? ST_SCALE : ST_IDLE;
        ST_SCALE: state_q <= ST_FILT;
        ST_FILT:  state_q <= ST_STORE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      raw_q    <= osb_pkg::DATA_RST;
      scaled_q <= osb_pkg::DATA_RST;
      filt_q   <= osb_pkg::DATA_RST;
    end else begin
      raw_q    <= (fifo_valid && fifo_ready) ? fifo_data : raw_q;
      scaled_q <= (state_q == ST_SCALE) ? sat16(scale_wide)
                                        : scaled_q;
      filt_q   <= (state_q == ST_FILT) ? filt_c : filt_q;
    end
  end

  // Filter history advances once per sample
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      x1_q <= osb_pkg::DATA_RST;
      x2_q <= osb_pkg::DATA_RST;
      y1_q <= osb_pkg::DATA_RST;
      y2_q <= osb_pkg::DATA_RST;
      lp_q <= osb_pkg::DATA_RST;
    end else if (state_q == ST_FILT) begin
      x1_q <= scaled_q;
      x2_q <= x1_q;
      y1_q <= (filter_mode == osb_pkg::FILT_LP2) ? sat16(lp2_w) : filt_c;
      y2_q <= y1_q;
      lp_q <= lp1_s;
    end
  end

  // ************************************************************
  // Line buffers and counter
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phys_buf_q <= '0;
      cnt_q      <= osb_pkg::CNT_RST;
    end else if (store_w) begin
      phys_buf_q <= {phys_buf_q[14:0], filt_q};
      cnt_q      <= cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      comp_buf_q <= 16'h0000;
    end else if (logic_tick) begin
      comp_buf_q <= {comp_buf_q[14:0], comp_bit};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      presc_q <= osb_pkg::PRESC_RST;
    end else if (sample_tick) begin
      presc_q <= presc_wrap ? osb_pkg::PRESC_RST : presc_q + 8'h01;
    end
  end

  // Set wins over clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      viol_q <= 1'b0;
      ovf_q  <= 1'b0;
    end else begin
      viol_q <= overrun || (viol_q && !clear_status);
      ovf_q  <= lost_sample || (ovf_q && !clear_status);
    end
  end

  // ************************************************************
  // Cyclic transfer image
  // ************************************************************
  wire logic [7:0] pending = cnt_q - deliv_q;
  wire logic [7:0] excess  = pending - ref_lines;
  wire logic [7:0] lag_ref = (excess > osb_pkg::LAG_MAX) ? osb_pkg::LAG_MAX
                                                         : excess;
  wire logic [7:0] lag     = (referenced_values && pending > ref_lines)
                             ? lag_ref : 8'h00;

  logic [13:0][15:0] img_c;
  always_comb begin
    for (int i = 0; i < 14; i++) begin
      logic [7:0] idx;
      idx = 8'(map_line[i]) + lag;
      img_c[i] = (idx < 8'h10) ? phys_buf_q[idx[3:0]] : 16'h0000;
    end
  end

  wire logic [7:0] status_c = {4'h0, referenced_values, high_priority,
                               ovf_q, viol_q};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      deliv_q                      <= osb_pkg::CNT_RST;
      xfer_valid_q                 <= 1'b0;
      xfer_status_q                <= 8'h00;
      new_line_counter_q           <= osb_pkg::CNT_RST;
      comparator_bits_upper_byte_q <= 8'h00;
      comparator_bits_lower_byte_q <= 8'h00;
      physical_line_point_q        <= '0;
    end else begin
      xfer_valid_q <= xfer_tick;
      if (xfer_tick) begin
        deliv_q                      <= cnt_q - lag;
        xfer_status_q                <= status_c;
        new_line_counter_q           <= cnt_q - lag;
        comparator_bits_upper_byte_q <= comp_buf_q[15:8];
        comparator_bits_lower_byte_q <= comp_buf_q[7:0];
        physical_line_point_q        <= img_c;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_counter_step: assert property (@(posedge clk_sys) disable iff (rst)
    store_w |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("counter did not step with stored line");

  a_buffer_shift: assert property (@(posedge clk_sys) disable iff (rst)
    store_w |=> phys_buf_q[1] == $past(phys_buf_q[0])
      && phys_buf_q[15] == $past(phys_buf_q[14]))
    else $error("line buffer did not shift by one");

  a_comp_oldest: assert property (@(posedge clk_sys) disable iff (rst)
    logic_tick |=> comp_buf_q[15] == $past(comp_buf_q[14]))
    else $error("oldest comparator bit misplaced");

  a_comp_newest: assert property (@(posedge clk_sys) disable iff (rst)
    logic_tick |=> comp_buf_q[0] == $past(comp_bit))
    else $error("newest comparator bit misplaced");

  a_cycle_violation: assert property (@(posedge clk_sys) disable iff (rst)
    high_priority && sample_tick && state_q != ST_IDLE
      |=> viol_q ##1 (viol_q || $past(clear_status)))
    else $error("overrun not flagged");

  a_current_count: assert property (@(posedge clk_sys) disable iff (rst)
    xfer_tick && !referenced_values
      |=> new_line_counter_q == $past(cnt_q))
    else $error("current mode counter not newest");

  a_ref_constant: assert property (@(posedge clk_sys) disable iff (rst)
    xfer_tick && referenced_values && pending >= ref_lines
      && excess <= osb_pkg::LAG_MAX
      |=> deliv_q == $past(deliv_q) + $past(ref_lines))
    else $error("referenced mode count not constant");

  a_sat_limits: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == ST_SCALE && scale_wide > 48'(osb_pkg::SAT_MAX)
      |=> scaled_q == osb_pkg::SAT_MAX)
    else $error("scaled value not saturated");

  a_comp_image: assert property (@(posedge clk_sys) disable iff (rst)
    xfer_tick |=> xfer_valid_q
      && {comparator_bits_upper_byte_q, comparator_bits_lower_byte_q}
         == $past(comp_buf_q) ##1 !xfer_valid_q || $past(xfer_tick))
    else $error("comparator image incomplete");

  a_state_walk: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == ST_SCALE |=> state_q == ST_FILT ##1 store_w)
    else $error("sample path skipped a stage");

endmodule : osb_chain

//--- osb_pkg.sv
package osb_pkg;

  // ************************************************************
  // Buffer geometry
  // ************************************************************
  localparam int unsigned LINES      = 16;
  localparam int unsigned LINE_W     = 4;
  localparam int unsigned POINTS     = 14;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned CNT_W      = 8;
  localparam int unsigned IMG_BYTES  = 2 + 2 * POINTS;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned PRESC_W    = 8;

  // ************************************************************
  // Fixed point formats
  // ************************************************************
  localparam int unsigned GAIN_FRAC = 12;
  localparam int unsigned COEF_FRAC = 14;
  localparam int unsigned LP_SH_W   = 4;

  // ************************************************************
  // Limits and reset values
  // ************************************************************
  localparam logic signed [15:0] SAT_MAX   = 16'sh7FFF;
  localparam logic signed [15:0] SAT_MIN   = -16'sh8000;
  localparam logic [CNT_W-1:0]   CNT_RST   = 8'h00;
  localparam logic [CNT_W-1:0]   LAG_MAX   = 8'h0F;
  localparam logic [DATA_W-1:0]  DATA_RST  = 16'h0000;
  localparam logic [PRESC_W-1:0] PRESC_RST = 8'h00;

  // ************************************************************
  // Status byte fields
  // ************************************************************
  localparam int unsigned ST_VIOL_BIT = 0;
  localparam int unsigned ST_OVF_BIT  = 1;
  localparam int unsigned ST_PRIO_BIT = 2;
  localparam int unsigned ST_REF_BIT  = 3;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    FILT_OFF,
    FILT_LP1,
    FILT_LP2,
    FILT_IIR
  } osb_filt_type;

endpackage : osb_pkg

//--- osb_fifo.sv
module osb_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Filling side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Draining side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             rdy_q;
  wire              push = in_valid && rdy_q;
  wire              pop  = out_valid && out_ready;

  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign in_ready  = rdy_q;
  assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      wr_q  <= push ? AW'(wr_q + 1'b1) : wr_q;
      rd_q  <= pop ? AW'(rd_q + 1'b1) : rd_q;
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d < (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

endmodule : osb_fifo

//--- osb_ctrl_model.sv
module osb_ctrl_model (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Bench side
  input  wire logic              xfer_req,
  input  wire logic              sparse,
  output logic       [7:0]       diff,
  output logic                   lost,
  // Device side
  output logic                   xfer_tick,
  output logic       [13:0][3:0] map_line,
  input  wire logic              xfer_valid_q,
  input  wire logic  [7:0]       new_line_counter_q
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] prev_q;
  logic [7:0] delta;
  logic [7:0] span;

  // ************************************************************
  // Point mapping: one line per point, or every second line
  // ************************************************************
  always_comb begin
    for (int i = 0; i < 14; i++) begin
      map_line[i] = sparse ? 4'((2 * i) % 16) : 4'(i);
    end
  end

  assign delta = new_line_counter_q - prev_q;
  assign span  = sparse ? 8'h0D : 8'h0E;

  // ************************************************************
  // Transfer cycle and counter bookkeeping
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      xfer_tick <= 1'b0;
      prev_q    <= 8'h00;
      diff      <= 8'h00;
      lost      <= 1'b0;
    end else begin
      xfer_tick <= xfer_req;
      if (xfer_valid_q) begin
        diff   <= delta;
        prev_q <= new_line_counter_q;
        lost   <= delta > span;
      end
    end
  end
endmodule : osb_ctrl_model

//--- osb_chain_bench.sv
module osb_chain_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk_sys, rst, raw_valid, raw_ready, sample_tick;
  logic                  comp_bit, clear_status, high_priority, xfer_req;
  logic                  referenced_values, sparse, lost, xfer_tick, xv;
  logic signed [15:0]    raw_value, fg, fo, ug, uo;
  logic        [15:0]    coef0, coef_z;
  logic        [3:0]     lp_shift;
  logic        [7:0]     prescale, ref_lines, status, cnt, up, lo, diff;
  logic        [13:0][3:0]  map_line;
  logic        [13:0][15:0] points;
  logic        [15:0]    exp_line [16];
  logic        [15:0]    exp_comp;
  osb_pkg::osb_filt_type filter_mode;
  int                    error_cnt, checks_done, seed, acc, pre_cnt;
  logic signed [15:0]    lp_st, x1, x2, y1, y2;

  osb_chain dut (.clk_sys(clk_sys), .rst(rst), .raw_value(raw_value),
    .raw_valid(raw_valid), .raw_ready(raw_ready), .sample_tick(sample_tick),
    .comp_bit(comp_bit), .factory_gain(fg), .factory_offset(fo),
    .user_gain(ug), .user_offset(uo), .filter_mode(filter_mode),
    .lp_shift(lp_shift), .numerator_coef_0(coef0), .numerator_coef_1(coef_z),
    .numerator_coef_2(coef_z), .denominator_coef_1(coef_z),
    .denominator_coef_2(coef_z), .high_priority(high_priority),
    .prescale(prescale), .referenced_values(referenced_values),
    .ref_lines(ref_lines), .clear_status(clear_status),
    .xfer_tick(xfer_tick), .map_line(map_line), .xfer_valid_q(xv),
    .xfer_status_q(status), .new_line_counter_q(cnt),
    .comparator_bits_upper_byte_q(up), .comparator_bits_lower_byte_q(lo),
    .physical_line_point_q(points));

  osb_ctrl_model ctrl (.clk_sys(clk_sys), .rst(rst), .xfer_req(xfer_req),
    .sparse(sparse), .diff(diff), .lost(lost), .xfer_tick(xfer_tick),
    .map_line(map_line), .xfer_valid_q(xv), .new_line_counter_q(cnt));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ************************************************************
  // Expectation and comparison helpers
  // ************************************************************
  function automatic logic [15:0] clip(input longint r);
    if (r > 32767) return 16'h7FFF;
    if (r < -32768) return 16'h8000;
    return 16'(r);
  endfunction : clip

  function automatic longint mq(input logic signed [15:0] a,
                                input logic signed [15:0] b);
    return (longint'(a) * longint'(b)) >>> osb_pkg::COEF_FRAC;
  endfunction : mq

  function automatic logic [15:0] exp_scale(input logic signed [15:0] raw);
    longint g, o, r;
    g = (longint'(fg) * longint'(ug)) >>> 12;
    o = ((longint'(fg) * longint'(fo)) >>> 12) + longint'(uo);
    r = ((g * longint'(raw)) >>> 12) + o;
    return clip(r);
  endfunction : exp_scale

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask : cmp

  // Filter history advances with every sample, whatever the mode
  task automatic shadow(input logic signed [15:0] v, input logic cb);
    logic signed [15:0] s, y;
    s = exp_scale(v);
    lp_st = 16'(lp_st + ((longint'(s) - lp_st) >>> lp_shift));
    y = s;
    if (filter_mode == osb_pkg::FILT_LP1) y = lp_st;
    if (filter_mode == osb_pkg::FILT_LP2)
      y = 16'(y1 + ((longint'(lp_st) - y1) >>> lp_shift));
    if (filter_mode == osb_pkg::FILT_IIR)
      y = clip(mq(coef0, s) + mq(coef_z, x1) + mq(coef_z, x2)
               - mq(coef_z, y1) - mq(coef_z, y2));
    {x2, x1, y2, y1} = {x1, s, y1, y};
    for (int i = 15; i > 0; i--) exp_line[i] = exp_line[i-1];
    exp_line[0] = y;
    if (high_priority) exp_comp = {exp_comp[14:0], cb};
  endtask : shadow

  task automatic push(input logic signed [15:0] v, input logic cb);
    int n;
    n = 0;
    // Offer only while ready: a refused word counts as lost
    while (raw_ready !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 200) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: raw_ready stayed low", $time);
    end
    raw_value = v;
    comp_bit  = cb;
    raw_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    raw_valid = 1'b0;
    shadow(v, cb);
    repeat (8) @(posedge clk_sys);
    #1;
    sample_tick = 1'b1;
    if (pre_cnt >= prescale) begin
      pre_cnt = 0;
      if (!high_priority) exp_comp = {exp_comp[14:0], cb};
    end else begin
      pre_cnt++;
    end
    @(posedge clk_sys);
    #1;
    sample_tick = 1'b0;
  endtask : push

  task automatic xfer();
    xfer_req = 1'b1;
    @(posedge clk_sys);
    #1;
    xfer_req = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : xfer

  task automatic pulse_clear();
    clear_status = 1'b1;
    @(posedge clk_sys);
    #1;
    clear_status = 1'b0;
  endtask : pulse_clear

  task automatic check_image(input int lag, input logic [7:0] nd,
                             input logic [7:0] st);
    int idx;
    for (int i = 0; i < 14; i++) begin
      idx = int'(map_line[i]) + lag;
      cmp(points[i], (idx > 15) ? 16'h0000 : exp_line[idx], "point");
    end
    cmp({8'h00, diff}, {8'h00, nd}, "count diff");
    cmp({8'h00, status}, {8'h00, st}, "status");
  endtask : check_image

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    seed = 20;
    rst = 1'b1;
    {raw_valid, sample_tick, comp_bit, clear_status, xfer_req} = 5'h00;
    {referenced_values, sparse} = 2'h0;
    high_priority = 1'b1;
    raw_value = 16'h0000;
    fg = 16'sh1000;
    ug = 16'sh2000;
    fo = 16'($random(seed)) & 16'h0FFF;
    uo = -(16'($random(seed)) & 16'h0FFF);
    coef0 = 16'h4000;
    coef_z = 16'h0000;
    lp_shift = 4'h0;
    prescale = 8'h00;
    ref_lines = 8'h02;
    filter_mode = osb_pkg::FILT_OFF;
    exp_comp = 16'h0000;
    for (int i = 0; i < 16; i++) exp_line[i] = 16'h0000;
    {lp_st, x1, x2, y1, y2} = '0;
    pre_cnt = 0;
    repeat (10) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    cmp({8'h00, cnt}, 16'h0000, "reset counter");
    cmp({up, lo}, 16'h0000, "reset comparator bits");
    // Every filter mode, lp_shift 1 for LP1/LP2, random other coefficients for IIR, 1 to 4 new lines
    for (int t = 0; t < 4; t++) begin
      filter_mode = osb_pkg::osb_filt_type'(t);
      sparse = (t == 3);
      lp_shift = 4'(t == 1 || t == 2);
      coef_z = (t == 3) ? 16'($random(seed)) & 16'h0FFF : 16'h0000;
      if (t == 0) push(16'sh7FFF, 1'b1);
      else push(16'($random(seed)), 1'($random(seed)));
      for (int k = 1; k <= t; k++) begin
        if (t == 1) push(-16'sh8000, 1'b0);
        else push(16'($random(seed)), 1'($random(seed)));
      end
      xfer();
      check_image(0, 8'(t + 1), 8'h04);
      cmp({up, lo}, exp_comp, "comparator bits");
      $display("test filter mode %0d done", t);
    end
    sparse = 1'b0;
    // Fourteen lines fit the image exactly
    for (int k = 0; k < 14; k++) push(16'($random(seed)), 1'($random(seed)));
    xfer();
    check_image(0, 8'h0E, 8'h04);
    cmp({up, lo}, exp_comp, "comparator full set");
    cmp({15'h0000, lost}, 16'h0000, "no loss");
    $display("test full image done");
    // Input overrun: FIFO refuses, lines are lost
    acc = 0;
    raw_value = 16'($random(seed));
    comp_bit = 1'b0;
    raw_valid = 1'b1;
    repeat (40) begin
      if (raw_ready === 1'b1) begin
        acc++;
        shadow(raw_value, 1'b0);
      end
      @(posedge clk_sys);
      #1;
    end
    raw_valid = 1'b0;
    repeat (120) @(posedge clk_sys);
    #1;
    xfer();
    check_image(0, 8'(acc), 8'h06);
    cmp({15'h0000, lost}, 16'h0001, "loss seen");
    pulse_clear();
    xfer();
    check_image(0, 8'h00, 8'h04);
    $display("test overrun done");
    // Sampling tick while a sample is still in process
    raw_value = 16'($random(seed));
    raw_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    raw_valid = 1'b0;
    shadow(raw_value, comp_bit);
    @(posedge clk_sys);
    #1;
    sample_tick = 1'b1;
    @(posedge clk_sys);
    #1;
    sample_tick = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    xfer();
    check_image(0, 8'h01, 8'h05);
    pulse_clear();
    xfer();
    check_image(0, 8'h00, 8'h04);
    $display("test cycle violation done");
    // Referenced values: ref_lines per transfer until fewer lines remain pending
    referenced_values = 1'b1;
    for (int k = 0; k < 5; k++) push(16'($random(seed)), 1'b1);
    xfer();
    check_image(3, 8'h02, 8'h0C);
    xfer();
    check_image(1, 8'h02, 8'h0C);
    xfer();
    check_image(0, 8'h01, 8'h0C);
    $display("test referenced values done");
    // Low priority: comparator bits follow the prescaled tick only
    {referenced_values, high_priority} = 2'h0;
    prescale = 8'h02;
    for (int k = 0; k < 6; k++) push(16'($random(seed)), 1'($random(seed)));
    xfer();
    check_image(0, 8'h06, 8'h00);
    cmp({up, lo}, exp_comp, "prescaled comparator bits");
    $display("test low priority done");
    complete_run();
  end
endmodule : osb_chain_bench
